// *** core/spmz_defines.svh ***
// constant macros for the serial port (modes zero and one)
`ifndef SPMZ_DEFINES_SVH
`define SPMZ_DEFINES_SVH

// ************************************************************
// register offsets
// ************************************************************
`define SPMZ_ADDR_CTRL     4'h0
`define SPMZ_ADDR_BUF      4'h1

// ************************************************************
// control register field positions
// ************************************************************
`define SPMZ_BIT_MODE      0
`define SPMZ_BIT_REN       1
`define SPMZ_BIT_QUAL      2
`define SPMZ_BIT_DBL       3
`define SPMZ_BIT_TDONE     4
`define SPMZ_BIT_RDONE     5
`define SPMZ_BIT_NINTH     6

// ************************************************************
// timing counts
// ************************************************************
`define SPMZ_SYNC_DIV_FAST 4'h4
`define SPMZ_SYNC_DIV_SLOW 4'hc
`define SPMZ_SYNC_LOW_FAST 4'h2
`define SPMZ_SYNC_LOW_SLOW 4'h6
`define SPMZ_SYNC_LEAD_FAST 4'h1
`define SPMZ_SYNC_LEAD_SLOW 4'h3
`define SPMZ_SYNC_BITS     4'h8
`define SPMZ_ASYNC_BITS    4'ha
`define SPMZ_SAMPLE_A      4'h7
`define SPMZ_SAMPLE_B      4'h8
`define SPMZ_SAMPLE_C      4'h9
`define SPMZ_SAMPLE_LAST   4'hf
`define SPMZ_RX_STOP_IDX   4'h9

`endif

// *** core/spmz_pkg.sv ***
// types shared by the serial port design
package spmz_pkg;

	// register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} spmz_req_s;

	// pin group toward the line
	typedef struct packed {
		logic data_out;
		logic data_oe_n;
		logic txd;
	} spmz_pins_s;

	typedef enum logic [3:0] {
		SPMZ_TX_IDLE  = 4'b0001,
		SPMZ_TX_SYNC  = 4'b0010,
		SPMZ_TX_ASYNC = 4'b0100,
		SPMZ_TX_RXSYN = 4'b1000
	} spmz_tx_e;

	typedef enum logic [2:0] {
		SPMZ_RX_HUNT  = 3'b001,
		SPMZ_RX_SHIFT = 3'b010,
		SPMZ_RX_HOLD  = 3'b100
	} spmz_rx_e;

endpackage

// *** core/spmz_serial_port.sv ***
// serial port, synchronous shift mode and ten-bit asynchronous mode
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
`include "spmz_defines.svh"

// Function
// - buffer writes transmit, buffer reads return receive
// - sync mode: data pin, clock on txd, lsb-first
// - qualifier picks fosc/12 or fosc/4 sync rate
// - buffer write starts eight-bit sync shift out
// - fast: data 1 clock early, low 2
// - slow: data 3 clocks early, low 6
// - sync transmit done after last bit
// - sync receive needs enable and done clear
// - sync receive done after last rising edge
// - async frame: start, eight data, stop
// - async rate is overflow over 16 or 32
// - async bits follow divide-by-16 rollovers
// - async transmit done at tenth rollover
// - async receive hunts falling edge every clock
// - falling edge resets divide-by-16 counter
// - two-of-three vote at states 7,8,9
// - nonzero start bit aborts reception
// - extra shift, load only if done clear
// - qualifier set needs stop bit one
// - after mid stop bit, hunt again
module spmz_serial_port (
	input  wire logic                clk_sys,   // system clock, 100 MHz
	input  wire logic                rstn,      // async reset, active low
	input  wire logic                clk_en,    // freezes all state but the reset synchroniser when low
	input  wire spmz_pkg::spmz_req_s req,       // register request
	output logic [7:0]               rdata,     // read data, cycle after read
	input  wire logic                ovf_pulse, // timer overflow, same domain
	input  wire logic                data_in,   // serial data pin level
	output spmz_pkg::spmz_pins_s     pins       // data out, enable, txd
);
	import spmz_pkg::*;

	// ************************************************************
	// reset release and pin synchronisers
	// ************************************************************
	logic       rst_s1_reg, rst_reg;
	logic       din_s1_reg, din_reg, din_prev_reg;
	logic       rst_n;

	// release of reset is synchronised, assertion is not
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rst_s1_reg <= 1'b0;
			rst_reg    <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_reg    <= rst_s1_reg;
		end
	end
	assign rst_n = rst_reg;

	// data pin through two flops before use
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			din_s1_reg   <= 1'b1;
			din_reg      <= 1'b1;
			din_prev_reg <= 1'b1;
		end else if (clk_en) begin
			din_s1_reg   <= data_in;
			din_reg      <= din_s1_reg;
			din_prev_reg <= din_reg;
		end
	end

	// ************************************************************
	// control register
	// ************************************************************
	logic       mode_reg, ren_reg, qual_reg, dbl_reg;
	logic       tdone_reg, rdone_reg, ninth_reg;
	logic [7:0] rxbuf_reg, txbuf_reg;
	logic       tdone_set, rx_load, tx_start, tx_go_reg;
	logic       ninth_next;
	logic [7:0] rxbuf_next;
	logic       wr_ctrl, wr_buf;

	assign wr_ctrl  = req.wr && (req.addr == `SPMZ_ADDR_CTRL);
	assign wr_buf   = req.wr && (req.addr == `SPMZ_ADDR_BUF);
	assign tx_start = tx_go_reg;

	// mode, enable, qualifier and rate select bits
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg <= 1'b0;
			ren_reg  <= 1'b0;
			qual_reg <= 1'b0;
			dbl_reg  <= 1'b0;
		end else if (clk_en && wr_ctrl) begin
			mode_reg <= req.wdata[`SPMZ_BIT_MODE];
			ren_reg  <= req.wdata[`SPMZ_BIT_REN];
			qual_reg <= req.wdata[`SPMZ_BIT_QUAL];
			dbl_reg  <= req.wdata[`SPMZ_BIT_DBL];
		end
	end

	// done flags: hardware set wins over software clear
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tdone_reg <= 1'b0;
			rdone_reg <= 1'b0;
		end else if (clk_en) begin
			if (tdone_set)
				tdone_reg <= 1'b1;
			else if (wr_ctrl)
				tdone_reg <= req.wdata[`SPMZ_BIT_TDONE];
			if (rx_load)
				rdone_reg <= 1'b1;
			else if (wr_ctrl)
				rdone_reg <= req.wdata[`SPMZ_BIT_RDONE];
		end
	end

	// receive buffer and ninth bit load only on a completed frame
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rxbuf_reg <= 8'h00;
			ninth_reg <= 1'b0;
		end else if (clk_en && rx_load) begin
			rxbuf_reg <= rxbuf_next;
			ninth_reg <= ninth_next;
		end
	end

	// writes land in the transmit register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			txbuf_reg <= 8'h00;
		else if (clk_en && wr_buf)
			txbuf_reg <= req.wdata;
	end

	// start one cycle after the write so the frame reads the stored byte;
	// a write while busy is stored but does not restart the frame
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			tx_go_reg <= 1'b0;
		else if (clk_en)
			tx_go_reg <= wr_buf;
	end

	// read data one cycle after the strobe
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else if (clk_en) begin
			if (!req.rd)
				rdata <= 8'h00;
			else if (req.addr == `SPMZ_ADDR_BUF)
				rdata <= rxbuf_reg;
			else if (req.addr == `SPMZ_ADDR_CTRL)
				rdata <= {1'b0, ninth_reg, rdone_reg, tdone_reg,
					dbl_reg, qual_reg, ren_reg, mode_reg};
			else
				rdata <= 8'h00;
		end
	end

	// ************************************************************
	// baud ticks: divide-by-16 transmit counter
	// ************************************************************
	logic       half_reg, baud16;
	logic [3:0] txdiv_reg;
	logic       tx_roll;

	// optional divide by two ahead of the x16 tick
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			half_reg <= 1'b0;
		else if (clk_en && ovf_pulse)
			half_reg <= ~half_reg;
	end
	assign baud16 = ovf_pulse && (dbl_reg || half_reg);

	// free running so bit timing ignores the moment of the write
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			txdiv_reg <= 4'h0;
		else if (clk_en && baud16)
			txdiv_reg <= txdiv_reg + 4'h1;
	end
	assign tx_roll = baud16 && (txdiv_reg == `SPMZ_SAMPLE_LAST);

	// ************************************************************
	// transmitter and synchronous engine
	// ************************************************************
	spmz_tx_e   tx_reg;
	logic [3:0] ph_reg, bits_reg;
	logic [9:0] sh_reg;
	logic       txd_reg, dout_reg, doe_n_reg;
	logic [3:0] div_len, low_len, lead_len;
	logic       sync_rx_go, sync_rise;
	logic [1:0] rise_pipe_reg, last_pipe_reg;
	logic [7:0] srx_reg;

	assign div_len    = qual_reg ? `SPMZ_SYNC_DIV_FAST : `SPMZ_SYNC_DIV_SLOW;
	assign low_len    = qual_reg ? `SPMZ_SYNC_LOW_FAST : `SPMZ_SYNC_LOW_SLOW;
	assign lead_len   = qual_reg ? `SPMZ_SYNC_LEAD_FAST : `SPMZ_SYNC_LEAD_SLOW;
	// no new receive clock while the last captured bit is still in flight
	assign sync_rx_go = !mode_reg && ren_reg && !rdone_reg && !(|rise_pipe_reg);

	// one sync bit period: high for the first part, low for the last
	// low_len clocks; the data pin changes at phase div_len-low_len-lead_len-1
	// so it leads the falling edge by lead_len clocks, a rise ends the bit
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_reg    <= SPMZ_TX_IDLE;
			ph_reg    <= 4'h0;
			bits_reg  <= 4'h0;
			sh_reg    <= 10'h3ff;
			txd_reg   <= 1'b1;
			dout_reg  <= 1'b1;
			doe_n_reg <= 1'b1;
			tdone_set <= 1'b0;
		end else if (clk_en) begin
			tdone_set <= 1'b0;
			case (tx_reg)
			SPMZ_TX_IDLE: begin
				txd_reg   <= 1'b1;
				doe_n_reg <= 1'b1;
				ph_reg    <= 4'h0;
				bits_reg  <= 4'h0;
				if (tx_start && !mode_reg) begin
					tx_reg    <= SPMZ_TX_SYNC;
					sh_reg    <= {2'b11, txbuf_reg};
					dout_reg  <= txbuf_reg[0];
					doe_n_reg <= 1'b0;
				end else if (tx_start) begin
					tx_reg <= SPMZ_TX_ASYNC;
					sh_reg <= {1'b1, txbuf_reg, 1'b0};
				end else if (sync_rx_go) begin
					tx_reg <= SPMZ_TX_RXSYN;
				end
			end
			SPMZ_TX_SYNC, SPMZ_TX_RXSYN: begin
				ph_reg <= ph_reg + 4'h1;
				if (ph_reg == div_len - low_len - 4'h1)
					txd_reg <= 1'b0;
				// data leads the clock fall by lead_len clocks
				if (tx_reg == SPMZ_TX_SYNC && ph_reg == div_len - low_len - lead_len - 4'h1)
					dout_reg <= sh_reg[0];
				if (ph_reg == div_len - 4'h1) begin
					txd_reg  <= 1'b1;
					ph_reg   <= 4'h0;
					bits_reg <= bits_reg + 4'h1;
					sh_reg   <= {1'b1, sh_reg[9:1]};
					if (bits_reg == `SPMZ_SYNC_BITS - 4'h1) begin
						tx_reg    <= SPMZ_TX_IDLE;
						doe_n_reg <= 1'b1;
						dout_reg  <= 1'b1;
						tdone_set <= (tx_reg == SPMZ_TX_SYNC);
					end
				end
			end
			SPMZ_TX_ASYNC: begin
				if (tx_roll) begin
					txd_reg  <= sh_reg[0];
					sh_reg   <= {1'b1, sh_reg[9:1]};
					bits_reg <= bits_reg + 4'h1;
					if (bits_reg == `SPMZ_ASYNC_BITS - 4'h1) begin
						tx_reg    <= SPMZ_TX_IDLE;
						tdone_set <= 1'b1;
					end
				end
			end
			default: tx_reg <= SPMZ_TX_IDLE;
			endcase
		end
	end

	assign pins = '{data_out: dout_reg, data_oe_n: doe_n_reg, txd: txd_reg};

	// sync receive capture: the pin is two flops late, so each bit is
	// taken two clocks after the clock rise, i.e. the level at the rise
	assign sync_rise = (tx_reg == SPMZ_TX_RXSYN) && (ph_reg == div_len - 4'h1);
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rise_pipe_reg <= 2'b00;
			last_pipe_reg <= 2'b00;
			srx_reg       <= 8'h00;
		end else if (clk_en) begin
			rise_pipe_reg <= {rise_pipe_reg[0], sync_rise};
			last_pipe_reg <= {last_pipe_reg[0],
				sync_rise && (bits_reg == `SPMZ_SYNC_BITS - 4'h1)};
			if (rise_pipe_reg[1])
				srx_reg <= {din_reg, srx_reg[7:1]};
		end
	end

	// ************************************************************
	// asynchronous receiver
	// ************************************************************
	spmz_rx_e   rx_reg;
	logic [3:0] rxdiv_reg, rxbits_reg;
	logic [2:0] vote_reg;
	logic [8:0] rxsh_reg;
	logic       bit_val;

	// two of three vote, used at each bit decision
	function automatic logic spmz_major(input logic [2:0] v);
		spmz_major = (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
	endfunction

	assign bit_val = spmz_major({din_reg, vote_reg[1:0]});

	// sync result: captured bits into buffer, no ninth bit in mode 0
	assign rxbuf_next = last_pipe_reg[1] ? {din_reg, srx_reg[7:1]} : rxsh_reg[8:1];
	assign ninth_next = last_pipe_reg[1] ? ninth_reg : bit_val;

	// load when the stop bit is decided; rdone is still clear
	assign rx_load = ((rx_reg == SPMZ_RX_SHIFT) && baud16 &&
		(rxdiv_reg == `SPMZ_SAMPLE_C) && (rxbits_reg == `SPMZ_RX_STOP_IDX) &&
		!rdone_reg && (!qual_reg || bit_val)) ||
		(last_pipe_reg[1] && !rdone_reg);

	// hunting stops until the stop bit is decided; a bad start drops back at once
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_reg     <= SPMZ_RX_HUNT;
			rxdiv_reg  <= 4'h0;
			rxbits_reg <= 4'h0;
			vote_reg   <= 3'h0;
			rxsh_reg   <= 9'h000;
		end else if (clk_en) begin
			case (rx_reg)
			SPMZ_RX_HUNT: begin
				if (mode_reg && ren_reg && din_prev_reg && !din_reg) begin
					rx_reg     <= SPMZ_RX_SHIFT;
					rxdiv_reg  <= 4'h0;
					rxbits_reg <= 4'h0;
				end
			end
			SPMZ_RX_SHIFT: begin
				if (baud16) begin
					rxdiv_reg <= rxdiv_reg + 4'h1;
					if (rxdiv_reg == `SPMZ_SAMPLE_A || rxdiv_reg == `SPMZ_SAMPLE_B)
						vote_reg <= {vote_reg[1:0], din_reg};
					if (rxdiv_reg == `SPMZ_SAMPLE_C) begin
						rxbits_reg <= rxbits_reg + 4'h1;
						rxsh_reg   <= {bit_val, rxsh_reg[8:1]};
						if (rxbits_reg == 4'h0 && bit_val)
							rx_reg <= SPMZ_RX_HUNT;
						else if (rxbits_reg == `SPMZ_RX_STOP_IDX)
							rx_reg <= SPMZ_RX_HOLD;
					end
				end
			end
			SPMZ_RX_HOLD: rx_reg <= SPMZ_RX_HUNT;
			default: rx_reg <= SPMZ_RX_HUNT;
			endcase
		end
	end

endmodule

// *** test/spmz_port_monitor.sv ***
// pin and register-port timing checker for the serial port
`timescale 1ns/1ps
`include "spmz_defines.svh"
module spmz_port_monitor (
	input wire logic                 clk_sys,   // system clock
	input wire logic                 rstn,      // reset, active low
	input wire spmz_pkg::spmz_req_s  req,       // register request
	input wire logic [7:0]           rdata,     // read data
	input wire logic                 ovf_pulse, // timer overflow
	input wire spmz_pkg::spmz_pins_s pins       // line pins
);
	import spmz_pkg::*;
	logic mode_reg;
	logic qual_reg;
	// mode bits are not visible on pins, so mirror them from control writes
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			mode_reg <= 1'b0;
			qual_reg <= 1'b0;
		end else if (req.wr && req.addr == `SPMZ_ADDR_CTRL) begin
			mode_reg <= req.wdata[`SPMZ_BIT_MODE];
			qual_reg <= req.wdata[`SPMZ_BIT_QUAL];
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// low phase of one shift clock bit, then back high
	sequence s_low2;
		(!pins.txd)[*2] ##1 pins.txd;
	endsequence
	sequence s_low6;
		(!pins.txd)[*6] ##1 pins.txd;
	endsequence
	a_read_idle: assert property (!$past(req.rd) |-> rdata == 8'h00)
		else $error("read data not zero outside a read");
	a_fast_low: assert property ($fell(pins.txd) && !mode_reg && qual_reg |-> s_low2)
		else $error("fast shift clock low time wrong");
	a_slow_low: assert property ($fell(pins.txd) && !mode_reg && !qual_reg |-> s_low6)
		else $error("slow shift clock low time wrong");
	a_fast_high: assert property ($rose(pins.txd) && !mode_reg && qual_reg |-> pins.txd[*2])
		else $error("fast shift clock high time short");
	a_slow_high: assert property ($rose(pins.txd) && !mode_reg && !qual_reg |-> pins.txd[*6])
		else $error("slow shift clock high time short");
	a_data_setup: assert property (!pins.data_oe_n && $fell(pins.txd) |->
		$stable(pins.data_out) ##1 $stable(pins.data_out))
		else $error("data moved too close to shift clock fall");
	a_drive_sync: assert property (!pins.data_oe_n |-> !mode_reg)
		else $error("data pin driven outside shift mode");
	a_tx_on_ovf: assert property (mode_reg && $changed(pins.txd) |->
		$past(ovf_pulse) || $past(ovf_pulse, 2) || $past(ovf_pulse, 3))
		else $error("async transmit bit not tied to overflow");
endmodule
bind spmz_serial_port spmz_port_monitor spmz_port_monitor_i (.clk_sys(clk_sys), .rstn(rstn),
	.req(req), .rdata(rdata), .ovf_pulse(ovf_pulse), .pins(pins));

// *** test/spmz_far_dev.sv ***
// external shift register and async sender on the data line
`timescale 1ns/1ps
module spmz_far_dev (
	input  wire logic clk_sys,   // bench clock for async bit timing
	input  wire logic txd,       // shift clock or async line
	input  wire logic data_oe_n, // low while the port drives data
	output logic      drv        // level this side puts on the line
);
	logic [7:0] sbyte = 8'h00;
	logic [3:0] idx = 4'h8;
	initial drv = 1'b1;
	// next bit goes out right at the clock fall, so it is settled by the rise
	always @(negedge txd) begin
		if (data_oe_n && idx < 4'h8) begin
			drv <= sbyte[idx[2:0]];
			idx <= idx + 4'h1;
		end
	end
	// after the last rise this side drives the line back high
	always @(posedge txd) begin
		if (data_oe_n && idx == 4'h8) begin
			drv <= 1'b1;
		end
	end
	task automatic load(input logic [7:0] b);
		sbyte = b;
		idx = 4'h0;
	endtask
	// start, eight data bits lsb first, stop; cyc clocks per bit
	task automatic send(input logic [7:0] b, input logic stop, input int cyc);
		logic [9:0] f;
		f = {stop, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			drv <= f[i];
			repeat (cyc) @(posedge clk_sys);
		end
		drv <= 1'b1;
	endtask
	task automatic glitch(input int cyc);
		drv <= 1'b0;
		repeat (cyc) @(posedge clk_sys);
		drv <= 1'b1;
	endtask
endmodule

// *** test/tb.sv ***
// self-checking bench for the serial port
`timescale 1ns/1ps
`include "spmz_defines.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
	import spmz_pkg::*;
	logic       clk_sys = 1'b0;
	logic       rstn = 1'b0;
	logic       ovf_pulse = 1'b0;
	logic       far_drv;
	logic [7:0] rdata;
	logic [7:0] v;
	logic [9:0] fr;
	logic [3:0] ovf_cnt = 4'h0;
	int         mismatches = 0;
	int         num_checks = 0;
	int         cyc = 0;
	spmz_req_s  req = '0;
	spmz_pins_s pins;
	wire logic  line = pins.data_oe_n ? far_drv : pins.data_out; // level on the data pin
	always #5 clk_sys = ~clk_sys;
	// overflow every 16 clocks (160 ns); cycle ceiling cuts a hang short
	always @(posedge clk_sys) begin
		ovf_cnt <= ovf_cnt + 4'h1;
		ovf_pulse <= (ovf_cnt == 4'hf);
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	spmz_serial_port spmz_serial_port_i (.clk_sys(clk_sys), .rstn(rstn), .clk_en(1'b1),
		.req(req), .rdata(rdata), .ovf_pulse(ovf_pulse), .data_in(line), .pins(pins));
	spmz_far_dev spmz_far_dev_i (.clk_sys(clk_sys), .txd(pins.txd),
		.data_oe_n(pins.data_oe_n), .drv(far_drv));
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clk_sys);
		req.wr <= 1'b0;
	endtask
	// read data is looked at only in the cycle after the strobe
	task automatic rchk(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk_sys);
		req.rd <= 1'b0;
		@(negedge clk_sys);
		`CHK(rdata, e)
	endtask
	task automatic wait_txd(input logic l);
		int n;
		n = 0;
		while (pins.txd !== l && n < 3000) begin
			@(negedge clk_sys);
			n++;
		end
	endtask
	task automatic tally_and_finish();
		if (mismatches == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		wr(4'h7, 8'hff);
		rchk(4'h7, 8'h00);
		rchk(`SPMZ_ADDR_CTRL, 8'h00);
		// shift out one byte at each rate; done flag must hold until cleared
		for (int q = 1; q >= 0; q--) begin
			wr(`SPMZ_ADDR_CTRL, {5'h00, q[0], 2'b00});
			wr(`SPMZ_ADDR_BUF, 8'h4d);
			for (int i = 0; i < 8; i++) begin
				wait_txd(1'b0);
				v[i] = line;
				`CHK(pins.data_oe_n, 1'b0)
				wait_txd(1'b1);
			end
			`CHK(v, 8'h4d)
			rchk(`SPMZ_ADDR_CTRL, {3'h0, 1'b1, 1'b0, q[0], 2'b00});
			repeat (50) @(negedge clk_sys);
			rchk(`SPMZ_ADDR_CTRL, {3'h0, 1'b1, 1'b0, q[0], 2'b00});
		end
		// shift in one byte; no clock may follow while the flag is set
		spmz_far_dev_i.load(8'h96);
		wr(`SPMZ_ADDR_CTRL, 8'h06);
		for (int i = 0; i < 8; i++) begin
			wait_txd(1'b0);
			wait_txd(1'b1);
		end
		repeat (4) @(negedge clk_sys);
		rchk(`SPMZ_ADDR_CTRL, 8'h26);
		rchk(`SPMZ_ADDR_BUF, 8'h96);
		for (int i = 0; i < 40; i++) begin
			@(negedge clk_sys);
			`CHK(pins.txd, 1'b1)
		end
		// async send at overflow/16, sampled mid-bit
		wr(`SPMZ_ADDR_CTRL, 8'h09);
		wr(`SPMZ_ADDR_BUF, 8'h5a);
		wait_txd(1'b0);
		repeat (128) @(negedge clk_sys);
		for (int i = 0; i < 10; i++) begin
			fr[i] = pins.txd;
			if (i == 9) rchk(`SPMZ_ADDR_CTRL, 8'h19);
			repeat (256) @(negedge clk_sys);
		end
		`CHK(fr, 10'h2b4)
		rchk(`SPMZ_ADDR_CTRL, 8'h19);
		// async receive, blocked by a set flag, refused stop bit, false start
		wr(`SPMZ_ADDR_CTRL, 8'h0b);
		spmz_far_dev_i.send(8'hc3, 1'b1, 256);
		rchk(`SPMZ_ADDR_BUF, 8'hc3);
		rchk(`SPMZ_ADDR_CTRL, 8'h6b);
		spmz_far_dev_i.send(8'h3c, 1'b1, 256);
		rchk(`SPMZ_ADDR_BUF, 8'hc3);
		wr(`SPMZ_ADDR_CTRL, 8'h0f);
		spmz_far_dev_i.send(8'h55, 1'b0, 256);
		repeat (300) @(negedge clk_sys);
		rchk(`SPMZ_ADDR_CTRL, 8'h4f);
		spmz_far_dev_i.glitch(3);
		repeat (600) @(negedge clk_sys);
		rchk(`SPMZ_ADDR_CTRL, 8'h4f);
		spmz_far_dev_i.send(8'ha6, 1'b1, 256);
		rchk(`SPMZ_ADDR_BUF, 8'ha6);
		tally_and_finish();
	end
endmodule
